// file: hdl/program_memory_page_mapper.sv
`timescale 1ns/1ps
// What this block does
// - a 12-bit instruction pointer is taken and every fetch goes through the mapper.
// - physical memory is four 2K pages, any of the four switchable into the lower half.
// - pointer bit 11 set always reaches the static page 1.
// - with bit 11 clear the two select bits pick page 0 to 3, other bits ignored.
// - selecting page 1 shows the static page in the lower window too.
// - the select register sits at data address ca and is write-only.
// - the select register resets to page 0 and holds it until software writes it.
// - interrupts, calls and returns leave the select register alone.
// - interrupt, nmi and reset vectors sit at the top of the static page.
// - the nmi input acts on its falling edge only and cannot be masked.
// - data addresses 40 to 7f form a window onto program memory.
module program_memory_page_mapper #(
    parameter int IP_W   = page_mapper_pkg::IP_W,
    parameter int PAGE_W = page_mapper_pkg::PAGE_W
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 fetch_req,
    input  wire logic [11:0]          instruction_pointer,
    input  wire logic                 data_wr,
    input  wire logic                 data_rd,
    input  wire logic [7:0]           data_addr,
    input  wire logic [7:0]           data_wdata,
    input  wire logic                 nmi_n,
    output logic                      mem_req,
    output logic [12:0]               mem_addr,
    output logic                      page_reg_hit,
    output logic                      rom_window_hit,
    output logic                      in_static,
    output page_mapper_pkg::region_e  fetch_region,
    output logic                      nmi_pending
);

    // =====================================================
    // size check
    if (IP_W != page_mapper_pkg::IP_W || PAGE_W != page_mapper_pkg::PAGE_W) begin : gen_size_check
        $error("page mapper serves only a 12-bit pointer and a 2-bit page number");
    end

    // =====================================================
    // decode helpers
    function automatic page_mapper_pkg::region_e region_of(input logic [11:0] ip);
        page_mapper_pkg::region_e r;
        r = page_mapper_pkg::REGION_USER;
        if (ip >= page_mapper_pkg::RESET_VEC_LO) begin
            r = page_mapper_pkg::REGION_RESET_VEC;
        end else if (ip >= page_mapper_pkg::NMI_VEC_LO) begin
            r = page_mapper_pkg::REGION_NMI_VEC;
        end else if (ip >= page_mapper_pkg::IRQ_VEC_LO && ip <= page_mapper_pkg::IRQ_VEC_HI) begin
            r = page_mapper_pkg::REGION_IRQ_VEC;
        end
        return r;
    endfunction : region_of

    function automatic logic [12:0] map_addr(input logic [11:0] ip, input logic [1:0] sel);
        logic [1:0] page;
        page = ip[page_mapper_pkg::PAGE_BIT_POS] ? page_mapper_pkg::STATIC_PAGE : sel;
        return {page, ip[10:0]};
    endfunction : map_addr

    // =====================================================
    // page select register
    logic [1:0] page_select_bits_r;
    logic [1:0] page_select_bits_nxt;
    logic       sel_wr;

    always_comb begin
        sel_wr               = data_wr && data_addr == page_mapper_pkg::PAGE_SELECT_ADDR;
        page_select_bits_nxt = page_select_bits_r;
        if (sel_wr) begin
            page_select_bits_nxt = data_wdata[1:0];
        end
    end

    // only the data write port alters it; no interrupt or call path reaches it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_select_bits_r <= page_mapper_pkg::PAGE_RESET;
        end else begin
            page_select_bits_r <= page_select_bits_nxt;
        end
    end

    // =====================================================
    // fetch mapping
    page_mapper_pkg::fetch_s fetch_r;
    page_mapper_pkg::fetch_s fetch_nxt;
    logic                    page_hit_r;
    logic                    page_hit_nxt;
    logic                    win_hit_r;
    logic                    win_hit_nxt;

    always_comb begin
        fetch_nxt.valid     = fetch_req;
        fetch_nxt.addr      = map_addr(instruction_pointer, page_select_bits_r);
        fetch_nxt.in_static = fetch_nxt.addr[12:11] == page_mapper_pkg::STATIC_PAGE;
        fetch_nxt.region    = instruction_pointer[page_mapper_pkg::PAGE_BIT_POS]
                              ? region_of(instruction_pointer) : page_mapper_pkg::REGION_USER;
        page_hit_nxt        = sel_wr;
        win_hit_nxt         = (data_rd || data_wr) && data_addr >= page_mapper_pkg::ROM_WIN_LO
                              && data_addr <= page_mapper_pkg::ROM_WIN_HI;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_r    <= '0;
            page_hit_r <= 1'b0;
            win_hit_r  <= 1'b0;
        end else begin
            fetch_r    <= fetch_nxt;
            page_hit_r <= page_hit_nxt;
            win_hit_r  <= win_hit_nxt;
        end
    end

    // =====================================================
    // nmi falling edge, no mask
    logic nmi_prev_r;
    logic nmi_prev_nxt;
    logic nmi_pend_r;
    logic nmi_pend_nxt;

    always_comb begin
        nmi_prev_nxt = nmi_n;
        nmi_pend_nxt = nmi_prev_r && !nmi_n;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_prev_r <= 1'b1;
            nmi_pend_r <= 1'b0;
        end else begin
            nmi_prev_r <= nmi_prev_nxt;
            nmi_pend_r <= nmi_pend_nxt;
        end
    end

    assign mem_req        = fetch_r.valid;
    assign mem_addr       = fetch_r.addr;
    assign in_static      = fetch_r.in_static;
    assign fetch_region   = fetch_r.region;
    assign page_reg_hit   = page_hit_r;
    assign rom_window_hit = win_hit_r;
    assign nmi_pending    = nmi_pend_r;

    // =====================================================
    // checks
    AST_UPPER_STATIC: assert property (@(posedge clk) disable iff (rst)
        fetch_req && instruction_pointer[page_mapper_pkg::PAGE_BIT_POS]
        |=> mem_addr[12:11] == page_mapper_pkg::STATIC_PAGE && mem_addr[10:0] == $past(instruction_pointer[10:0]))
        else $error("upper half not on static page");
    AST_LOWER_SELECT: assert property (@(posedge clk) disable iff (rst)
        fetch_req && !instruction_pointer[page_mapper_pkg::PAGE_BIT_POS]
        |=> mem_addr[12:11] == $past(page_select_bits_r))
        else $error("lower half ignores select bits");
    AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (rst)
        data_wr && data_addr == page_mapper_pkg::PAGE_SELECT_ADDR
        |=> page_select_bits_r == $past(data_wdata[1:0]) && page_reg_hit)
        else $error("page write not stored");
    AST_HOLD: assert property (@(posedge clk) disable iff (rst)
        !(data_wr && data_addr == page_mapper_pkg::PAGE_SELECT_ADDR) |=> $stable(page_select_bits_r))
        else $error("page register changed without write");
    AST_NEW_PAGE: assert property (@(posedge clk) disable iff (rst)
        data_wr && data_addr == page_mapper_pkg::PAGE_SELECT_ADDR
        ##1 fetch_req && !instruction_pointer[page_mapper_pkg::PAGE_BIT_POS]
        |=> mem_addr[12:11] == $past(data_wdata[1:0], 2))
        else $error("new page not applied next fetch");
    AST_NO_PAGE_READ: assert property (@(posedge clk) disable iff (rst)
        data_rd && !data_wr && data_addr == page_mapper_pkg::PAGE_SELECT_ADDR
        |=> !page_reg_hit && $stable(page_select_bits_r))
        else $error("read of page register had an effect");
    AST_STATIC_FLAG: assert property (@(posedge clk) disable iff (rst)
        fetch_req |=> in_static == ($past(instruction_pointer[page_mapper_pkg::PAGE_BIT_POS])
                                    || $past(page_select_bits_r) == page_mapper_pkg::STATIC_PAGE))
        else $error("static flag wrong");
    AST_STATIC_ALIAS: assert property (@(posedge clk) disable iff (rst)
        fetch_req && !instruction_pointer[page_mapper_pkg::PAGE_BIT_POS]
        && page_select_bits_r == page_mapper_pkg::STATIC_PAGE
        |=> mem_addr[12:11] == page_mapper_pkg::STATIC_PAGE && in_static)
        else $error("static page not seen through lower window");
    AST_VECTOR: assert property (@(posedge clk) disable iff (rst)
        fetch_req && instruction_pointer >= page_mapper_pkg::RESET_VEC_LO
        |=> fetch_region == page_mapper_pkg::REGION_RESET_VEC)
        else $error("reset vector region wrong");
    AST_NMI_VECTOR: assert property (@(posedge clk) disable iff (rst)
        fetch_req && instruction_pointer >= page_mapper_pkg::NMI_VEC_LO
        && instruction_pointer < page_mapper_pkg::RESET_VEC_LO
        |=> fetch_region == page_mapper_pkg::REGION_NMI_VEC)
        else $error("nmi vector region wrong");
    AST_IRQ_VECTOR: assert property (@(posedge clk) disable iff (rst)
        fetch_req && instruction_pointer >= page_mapper_pkg::IRQ_VEC_LO
        && instruction_pointer <= page_mapper_pkg::IRQ_VEC_HI
        |=> fetch_region == page_mapper_pkg::REGION_IRQ_VEC)
        else $error("interrupt vector region wrong");
    AST_USER_REGION: assert property (@(posedge clk) disable iff (rst)
        fetch_req && !instruction_pointer[page_mapper_pkg::PAGE_BIT_POS]
        |=> fetch_region == page_mapper_pkg::REGION_USER)
        else $error("lower half fetch marked as vector");
    AST_WINDOW: assert property (@(posedge clk) disable iff (rst)
        data_rd && data_addr >= page_mapper_pkg::ROM_WIN_LO && data_addr <= page_mapper_pkg::ROM_WIN_HI
        |=> rom_window_hit)
        else $error("rom window missed");
    AST_WINDOW_OUT: assert property (@(posedge clk) disable iff (rst)
        data_addr < page_mapper_pkg::ROM_WIN_LO || data_addr > page_mapper_pkg::ROM_WIN_HI
        |=> !rom_window_hit)
        else $error("rom window hit outside its range");
    AST_NMI_EDGE: assert property (@(posedge clk) disable iff (rst)
        nmi_pending |-> $past(nmi_n, 2) && !$past(nmi_n))
        else $error("nmi without falling edge");
    AST_NMI_FALL: assert property (@(posedge clk) disable iff (rst)
        $fell(nmi_n) |=> nmi_pending)
        else $error("nmi falling edge lost");
    AST_NMI_ONCE: assert property (@(posedge clk) disable iff (rst)
        nmi_pending |=> !nmi_pending)
        else $error("nmi pending longer than one cycle");
    AST_FETCH_REQ: assert property (@(posedge clk) disable iff (rst)
        fetch_req |=> mem_req)
        else $error("fetch not forwarded");

    // =====================================================
    // scenario covers
    COV_PAGE3: cover property (@(posedge clk) disable iff (rst) mem_req && mem_addr[12:11] == 2'h3);
    COV_SWITCH: cover property (@(posedge clk) disable iff (rst) page_reg_hit ##1 mem_req && !in_static);
    COV_NMI: cover property (@(posedge clk) disable iff (rst) nmi_pending);
    COV_ALIAS: cover property (@(posedge clk) disable iff (rst) mem_req && in_static && fetch_region == page_mapper_pkg::REGION_USER);
    COV_RESET_VEC: cover property (@(posedge clk) disable iff (rst)
        mem_req && fetch_region == page_mapper_pkg::REGION_RESET_VEC);

endmodule : program_memory_page_mapper

// file: hdl/page_mapper_pkg.sv
package page_mapper_pkg;

    // =====================================================
    // widths
    localparam int IP_W        = 12;
    localparam int PHYS_W      = 13;
    localparam int DADDR_W     = 8;
    localparam int DATA_W      = 8;
    localparam int PAGE_W      = 2;

    // =====================================================
    // data space map
    localparam logic [7:0] PAGE_SELECT_ADDR = 8'hca;
    localparam logic [7:0] ROM_WIN_LO       = 8'h40;
    localparam logic [7:0] ROM_WIN_HI       = 8'h7f;

    // =====================================================
    // program space map
    localparam int          PAGE_BIT_POS  = 11;
    localparam logic [1:0]  STATIC_PAGE   = 2'h1;
    localparam logic [1:0]  PAGE_RESET    = 2'h0;
    localparam logic [11:0] IRQ_VEC_LO    = 12'hff0;
    localparam logic [11:0] IRQ_VEC_HI    = 12'hff7;
    localparam logic [11:0] NMI_VEC_LO    = 12'hffc;
    localparam logic [11:0] RESET_VEC_LO  = 12'hffe;

    typedef enum logic [1:0] {
        REGION_USER,
        REGION_IRQ_VEC,
        REGION_NMI_VEC,
        REGION_RESET_VEC
    } region_e;

    typedef struct packed {
        logic [12:0] addr;
        logic        valid;
        logic        in_static;
        region_e     region;
    } fetch_s;

endpackage : page_mapper_pkg

// file: test/cpu_side_model.sv
`timescale 1ns/1ps
// =====================================
// cpu side: fetch, data access, nmi line
module cpu_side_model (
    input  wire logic        clk,
    output logic             fetch_req,
    output logic [11:0]      instruction_pointer,
    output logic             data_wr,
    output logic             data_rd,
    output logic [7:0]       data_addr,
    output logic [7:0]       data_wdata,
    output logic             nmi_n
);
    initial {fetch_req, instruction_pointer, data_wr, data_rd, data_addr, data_wdata, nmi_n} = 32'h1;
    // whole-byte writes only, never bit operations
    task automatic drive(input logic [31:0] v);
        @(posedge clk);
        {fetch_req, instruction_pointer, data_wr, data_rd, data_addr, data_wdata, nmi_n} <= v;
    endtask : drive
    // released address and data lines show inverse of last value, strobes go low, nmi line kept
    task automatic idle;
        @(posedge clk);
        fetch_req <= 1'b0;
        data_wr <= 1'b0;
        data_rd <= 1'b0;
        instruction_pointer <= ~instruction_pointer;
        data_addr <= ~data_addr;
        data_wdata <= ~data_wdata;
    endtask : idle
endmodule : cpu_side_model

// file: test/program_memory_page_mapper_tb.sv
`timescale 1ns/1ps
module program_memory_page_mapper_tb;
    localparam logic [7:0] SA = page_mapper_pkg::PAGE_SELECT_ADDR;
    logic clk, rst, fetch_req, data_wr, data_rd, nmi_n, nmi_lvl;
    logic [11:0] instruction_pointer;
    logic [7:0] data_addr, data_wdata;
    logic mem_req, page_reg_hit, rom_window_hit, in_static, nmi_pending;
    logic [12:0] mem_addr;
    page_mapper_pkg::region_e fetch_region;
    logic [1:0] sel;
    logic [15:0] lfsr_r;
    logic [11:0] vec [8] = '{12'hff0, 12'hff7, 12'hff8, 12'hffb, 12'hffc, 12'hffd, 12'hffe, 12'hfff};
    logic [7:0] win [5] = '{8'h3f, 8'h40, 8'h7f, 8'h80, 8'hca};
    int err_count, check_count;
    cpu_side_model i_cpu_side_model (.clk, .fetch_req, .instruction_pointer, .data_wr, .data_rd,
        .data_addr, .data_wdata, .nmi_n);
    program_memory_page_mapper i_program_memory_page_mapper (.clk, .rst, .fetch_req, .instruction_pointer,
        .data_wr, .data_rd, .data_addr, .data_wdata, .nmi_n, .mem_req, .mem_addr, .page_reg_hit,
        .rom_window_hit, .in_static, .fetch_region, .nmi_pending);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    function automatic logic [12:0] exp_addr(input logic [1:0] s, input logic [11:0] a);
        return {a[11] ? page_mapper_pkg::STATIC_PAGE : s, a[10:0]};
    endfunction : exp_addr
    function automatic logic [1:0] exp_region(input logic [11:0] a);
        if (a >= page_mapper_pkg::RESET_VEC_LO) return 2'h3;
        if (a >= page_mapper_pkg::NMI_VEC_LO) return 2'h2;
        if (a >= page_mapper_pkg::IRQ_VEC_LO && a <= page_mapper_pkg::IRQ_VEC_HI) return 2'h1;
        return 2'h0;
    endfunction : exp_region
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    task automatic cyc(input logic f, input logic [11:0] ip, input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        i_cpu_side_model.drive({f, ip, w, ~f & ~w, a, d, nmi_lvl});
        i_cpu_side_model.idle();
        #1;
    endtask : cyc
    task automatic fetch(input logic [11:0] ip);
        cyc(1'b1, ip, 1'b0, 8'h00, 8'h00);
        check(16'(mem_req), 16'h1);
        check(16'(mem_addr), 16'(exp_addr(sel, ip)));
        check(16'(in_static), 16'(exp_addr(sel, ip) >> 11 == 13'(page_mapper_pkg::STATIC_PAGE)));
        check(16'(fetch_region), 16'(exp_region(ip)));
    endtask : fetch
    task automatic dacc(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc(1'b0, 12'h000, w, a, d);
        check(16'(page_reg_hit), 16'(w && a == SA));
        check(16'(rom_window_hit), 16'(a >= page_mapper_pkg::ROM_WIN_LO && a <= page_mapper_pkg::ROM_WIN_HI));
        if (w && a == SA) sel = d[1:0];
    endtask : dacc
    initial begin
        rst = 1'b1;
        nmi_lvl = 1'b1;
        sel = page_mapper_pkg::PAGE_RESET;
        lfsr_r = 16'h0f9c;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        fetch(12'h7ff);
        for (int p = 0; p < 8; p++) begin
            lfsr_r = lfsr_next(lfsr_r);
            dacc(1'b1, SA, {lfsr_r[7:2], p[1:0]});
            fetch({1'b0, lfsr_r[15:5]});
            fetch({1'b1, lfsr_r[10:0]});
        end
        foreach (vec[i]) fetch(vec[i]);
        dacc(1'b0, SA, 8'h03);
        dacc(1'b1, 8'hcb, 8'h02);
        foreach (win[i]) dacc(1'b0, win[i], 8'h00);
        // ram image first, then the page register
        dacc(1'b1, 8'h90, 8'h03);
        dacc(1'b1, SA, 8'h03);
        fetch(12'h3a5);
        // static page, then page write and dynamic fetch back to back
        fetch(12'h900);
        i_cpu_side_model.drive({1'b0, 12'h000, 1'b1, 1'b0, SA, 8'hfe, nmi_lvl});
        i_cpu_side_model.drive({1'b1, 12'h055, 18'h0, nmi_lvl});
        i_cpu_side_model.idle();
        #1;
        sel = 2'h2;
        check(16'(mem_addr), 16'h1055);
        nmi_lvl = 1'b0;
        dacc(1'b0, 8'h10, 8'h00);
        check(16'(nmi_pending), 16'h1);
        @(posedge clk);
        #1;
        check(16'(nmi_pending), 16'h0);
        nmi_lvl = 1'b1;
        dacc(1'b0, 8'h10, 8'h00);
        check(16'(nmi_pending), 16'h0);
        fetch(12'h055);
        // second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(16'({mem_req, page_reg_hit, rom_window_hit, in_static, nmi_pending, fetch_region}), 16'h0000);
        check(16'(mem_addr), 16'h0000);
        @(posedge clk);
        rst <= 1'b0;
        sel = page_mapper_pkg::PAGE_RESET;
        fetch(12'h123);
        close_out();
    end
endmodule : program_memory_page_mapper_tb
